// >>> common/ism_pkg.sv
// Constants, types and carriers shared by the serial-target and mode-control core.
// Assumes a single 100 MHz system clock; register indices are 8-bit I2C register addresses.
package ism_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus addresses and register map
  localparam logic [6:0] ADDR_SEL_LOW = 7'h2c;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h2d;
  localparam logic [7:0] CTRL_REG_IDX = 8'h01;
  localparam logic [7:0] SLEEP_REG_IDX = 8'h02;
  localparam logic [7:0] SOFT_RST_IDX = 8'h7f;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h55aa;
  localparam logic [15:0] REG_RST_VAL = 16'h0000;

  // Field positions in the global control register
  localparam int unsigned LED_ENABLE_POS = 0;
  localparam int unsigned SENSE_ENABLE_POS = 1;
  localparam int unsigned NUM_CH = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OSC_START_NS = 5000;
  // Least time: round up to whole cycles
  localparam int unsigned OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    ISM_MODE_SHUTDOWN = 2'b00,
    ISM_MODE_STANDBY  = 2'b01,
    ISM_MODE_ACTIVE   = 2'b10
  } ism_mode_t;

  typedef enum logic [3:0] {
    ISM_ST_IDLE  = 4'b0000,
    ISM_ST_ADDR  = 4'b0001,
    ISM_ST_INDEX = 4'b0010,
    ISM_ST_DHI   = 4'b0011,
    ISM_ST_DLO   = 4'b0100,
    ISM_ST_ACK   = 4'b0101,
    ISM_ST_SEND  = 4'b0110,
    ISM_ST_MACK  = 4'b0111,
    ISM_ST_WAIT  = 4'b1000
  } ism_state_t;

  typedef struct packed {
    ism_mode_t mode;
    logic osc_en;
    logic osc_ready;
    logic sense_rst;
    logic led_rst;
    logic [NUM_CH-1:0] ch_en;
  } ism_ctrl_t;

endpackage : ism_pkg

// >>> core/ism_core.sv
// I2C register-access target with work-mode, oscillator and channel-enable control.
// Assumes SCL, SDA, address-select and power-down pins are asynchronous to clk_i and
// that SDA is resolved as open-drain outside (sda_oe_o high pulls the line low).
`timescale 1ns/1ps

// Notes on behaviour
// - Address 0x2C select low, 0x2D high.
// - Target only, fast mode up to 400kHz.
// - Acknowledge address byte only on match.
// - Write data upper byte first, then lower.
// - Bytes eight bits, MSB first, then ack.
// - SDA change during SCL high aborts transfer.
// - Read returns upper byte, then lower byte.
// - Master ack on lower byte increments index.
// - Master nack: release data, await stop.
// - Power-down low holds shutdown, all inactive.
// - Power-down rising edge resets registers, standby.
// - Standby: functions off, serial port works.
// - Either enable bit set enters active.
// - Writing 0x55AA to soft reset resets registers.
// - Oscillator runs with either enable, 5us start.
// - Sense enable low holds touch in reset.
// - Channel sleep bit one powers channel off.
// - Control 0x01 LED, 0x02 touch, 0x03 both.
module ism_core #(
  parameter int unsigned REG_COUNT = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_sel_i,
  input wire logic power_down_n_pin_i,
  output ism_pkg::ism_ctrl_t ctrl_o
);

  localparam int unsigned AW = (REG_COUNT > 1) ? $clog2(REG_COUNT) : 1;

  if (REG_COUNT < 3 || REG_COUNT > 127) begin : g_bad_count
    $error("REG_COUNT must hold the control registers and stay below the reset index");
  end

  function automatic logic in_map(input logic [7:0] idx);
    in_map = (32'(idx) < REG_COUNT);
  endfunction : in_map

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one is read only by stage two
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] asel_sync_q;
  logic [1:0] pwr_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic pwr_prev_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      asel_sync_q <= 2'h0;
      pwr_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      pwr_prev_q <= 1'b0;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      asel_sync_q <= {asel_sync_q[0], addr_sel_i};
      pwr_sync_q <= {pwr_sync_q[0], power_down_n_pin_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
      pwr_prev_q <= pwr_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic pwr_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic por_pulse;
  logic [6:0] own_addr;

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign pwr_s = pwr_sync_q[1];
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // Any SDA edge with SCL high is a start or stop and ends what was in progress
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign por_pulse = pwr_s & ~pwr_prev_q;
  // Floating pin reads low thanks to the internal pull-down
  assign own_addr = asel_sync_q[1] ? ism_pkg::ADDR_SEL_HIGH : ism_pkg::ADDR_SEL_LOW;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [15:0] regs_q [REG_COUNT];
  logic wr_q;
  logic [7:0] wr_idx_q;
  logic [15:0] wr_data_q;
  logic soft_rst;
  logic clear_regs;

  assign soft_rst = wr_q & (wr_idx_q == ism_pkg::SOFT_RST_IDX) & (wr_data_q == ism_pkg::SOFT_RESET_KEY);
  assign clear_regs = ~pwr_s | por_pulse | soft_rst;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs_q[i] <= ism_pkg::REG_RST_VAL;
      end
    end
    else if (clear_regs)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs_q[i] <= ism_pkg::REG_RST_VAL;
      end
    end
    else if (wr_q && in_map(wr_idx_q))
    begin
      // Writable in standby as well as active
      regs_q[wr_idx_q[AW-1:0]] <= wr_data_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial target, sampled from the system clock so it never needs the gated oscillator
  ism_pkg::ism_state_t state_q;
  ism_pkg::ism_state_t after_ack_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] idx_q;
  logic [7:0] data_hi_q;
  logic [7:0] tx_q;
  logic lo_sent_q;
  logic master_ack_q;
  logic sda_oe_q;
  logic [15:0] cur_word;
  logic [15:0] nxt_word;
  logic [7:0] idx_inc;

  assign idx_inc = idx_q + 8'h01;
  // Unmapped indices read as zero
  assign cur_word = in_map(idx_q) ? regs_q[idx_q[AW-1:0]] : 16'h0000;
  assign nxt_word = in_map(idx_inc) ? regs_q[idx_inc[AW-1:0]] : 16'h0000;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ism_pkg::ISM_ST_IDLE;
      after_ack_q <= ism_pkg::ISM_ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q <= 8'h00;
      idx_q <= 8'h00;
      data_hi_q <= 8'h00;
      tx_q <= 8'h00;
      lo_sent_q <= 1'b0;
      master_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_q <= 1'b0;
      wr_idx_q <= 8'h00;
      wr_data_q <= 16'h0000;
    end
    else
    begin
      wr_q <= 1'b0;
      if (!pwr_s)
      begin
        // Port dead in shutdown
        state_q <= ism_pkg::ISM_ST_IDLE;
        sda_oe_q <= 1'b0;
        idx_q <= 8'h00;
      end
      else if (start_det)
      begin
        // Start or repeated start; an unfinished write is dropped
        state_q <= ism_pkg::ISM_ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end
      else if (stop_det)
      begin
        state_q <= ism_pkg::ISM_ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state_q == ism_pkg::ISM_ST_MACK)
        begin
          master_ack_q <= ~sda_s;
        end
        else if (bit_cnt_q != ism_pkg::BYTE_BITS)
        begin
          rx_q <= {rx_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
      else if (scl_fall)
      begin
        case (state_q)
          ism_pkg::ISM_ST_ADDR:
          begin
            if (bit_cnt_q == ism_pkg::BYTE_BITS)
            begin
              if (rx_q[7:1] == own_addr)
              begin
                sda_oe_q <= 1'b1;
                state_q <= ism_pkg::ISM_ST_ACK;
                after_ack_q <= rx_q[0] ? ism_pkg::ISM_ST_SEND : ism_pkg::ISM_ST_INDEX;
              end
              else
              begin
                state_q <= ism_pkg::ISM_ST_IDLE;
              end
            end
          end
          ism_pkg::ISM_ST_INDEX:
          begin
            if (bit_cnt_q == ism_pkg::BYTE_BITS)
            begin
              idx_q <= rx_q;
              sda_oe_q <= 1'b1;
              state_q <= ism_pkg::ISM_ST_ACK;
              after_ack_q <= ism_pkg::ISM_ST_DHI;
            end
          end
          ism_pkg::ISM_ST_DHI:
          begin
            if (bit_cnt_q == ism_pkg::BYTE_BITS)
            begin
              data_hi_q <= rx_q;
              sda_oe_q <= 1'b1;
              state_q <= ism_pkg::ISM_ST_ACK;
              after_ack_q <= ism_pkg::ISM_ST_DLO;
            end
          end
          ism_pkg::ISM_ST_DLO:
          begin
            if (bit_cnt_q == ism_pkg::BYTE_BITS)
            begin
              sda_oe_q <= 1'b1;
              state_q <= ism_pkg::ISM_ST_ACK;
              after_ack_q <= ism_pkg::ISM_ST_WAIT;
              wr_idx_q <= idx_q;
              wr_data_q <= {data_hi_q, rx_q};
            end
          end
          ism_pkg::ISM_ST_ACK:
          begin
            bit_cnt_q <= 4'h0;
            state_q <= after_ack_q;
            if (after_ack_q == ism_pkg::ISM_ST_SEND)
            begin
              tx_q <= cur_word[15:8];
              sda_oe_q <= ~cur_word[15];
              lo_sent_q <= 1'b0;
            end
            else
            begin
              sda_oe_q <= 1'b0;
            end
            // Commit once the lower byte's ack slot is over
            if (after_ack_q == ism_pkg::ISM_ST_WAIT)
            begin
              wr_q <= 1'b1;
            end
          end
          ism_pkg::ISM_ST_SEND:
          begin
            if (bit_cnt_q == ism_pkg::BYTE_BITS)
            begin
              sda_oe_q <= 1'b0;
              state_q <= ism_pkg::ISM_ST_MACK;
            end
            else
            begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
          ism_pkg::ISM_ST_MACK:
          begin
            bit_cnt_q <= 4'h0;
            if (!master_ack_q)
            begin
              state_q <= ism_pkg::ISM_ST_WAIT;
            end
            else if (!lo_sent_q)
            begin
              state_q <= ism_pkg::ISM_ST_SEND;
              tx_q <= cur_word[7:0];
              sda_oe_q <= ~cur_word[7];
              lo_sent_q <= 1'b1;
            end
            else
            begin
              state_q <= ism_pkg::ISM_ST_SEND;
              idx_q <= idx_inc;
              tx_q <= nxt_word[15:8];
              sda_oe_q <= ~nxt_word[15];
              lo_sent_q <= 1'b0;
            end
          end
          default:
          begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain: only ever pulls low; never drives SCL
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Work mode, oscillator gating and channel enables
  logic [15:0] glb_ctrl;
  logic [15:0] ch_sleep;
  logic any_en;
  logic [15:0] osc_cnt_q;
  ism_pkg::ism_ctrl_t ctrl_d;
  ism_pkg::ism_ctrl_t ctrl_q;

  assign glb_ctrl = regs_q[ism_pkg::CTRL_REG_IDX[AW-1:0]];
  assign ch_sleep = regs_q[ism_pkg::SLEEP_REG_IDX[AW-1:0]];
  assign any_en = pwr_s & (glb_ctrl[ism_pkg::LED_ENABLE_POS] | glb_ctrl[ism_pkg::SENSE_ENABLE_POS]);

  // Start-up wait restarts whenever the oscillator is gated off
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_cnt_q <= 16'h0000;
    end
    else if (!any_en)
    begin
      osc_cnt_q <= 16'h0000;
    end
    else if (32'(osc_cnt_q) < ism_pkg::OSC_START_CYC)
    begin
      osc_cnt_q <= osc_cnt_q + 16'h0001;
    end
  end

  always_comb
  begin
    ctrl_d.osc_en = any_en;
    ctrl_d.osc_ready = any_en & (32'(osc_cnt_q) >= ism_pkg::OSC_START_CYC);
    ctrl_d.sense_rst = ~(pwr_s & glb_ctrl[ism_pkg::SENSE_ENABLE_POS]);
    ctrl_d.led_rst = ~(pwr_s & glb_ctrl[ism_pkg::LED_ENABLE_POS]);
    for (int i = 0; i < ism_pkg::NUM_CH; i++)
    begin
      ctrl_d.ch_en[i] = ~ctrl_d.sense_rst & ~ch_sleep[i];
    end
    if (!pwr_s)
    begin
      ctrl_d.mode = ism_pkg::ISM_MODE_SHUTDOWN;
    end
    else if (any_en)
    begin
      ctrl_d.mode = ism_pkg::ISM_MODE_ACTIVE;
    end
    else
    begin
      ctrl_d.mode = ism_pkg::ISM_MODE_STANDBY;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= '{mode: ism_pkg::ISM_MODE_SHUTDOWN, osc_en: 1'b0, osc_ready: 1'b0,
                  sense_rst: 1'b1, led_rst: 1'b1, ch_en: '0};
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl_o = ctrl_q;

endmodule : ism_core

// >>> dv/ism_core_checker.sv
// Assertions on the pins and control outputs of ism_core.
// Assumes a bind to ism_core; all checks run in the clk_i domain.
`timescale 1ns/1ps
module ism_core_checker #(
  parameter int unsigned REG_COUNT = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic addr_sel_i,
  input wire logic power_down_n_pin_i,
  input wire ism_pkg::ism_ctrl_t ctrl_o
);
  logic [9:0] on_q;
  logic act;
  assign act = ctrl_o.mode == ism_pkg::ISM_MODE_ACTIVE;
  // Cycles the oscillator enable has been up, saturating
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      on_q <= 10'h000;
    else if (!ctrl_o.osc_en)
      on_q <= 10'h000;
    else if (on_q != 10'h3ff)
      on_q <= on_q + 10'h001;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Four samples low: past the pin synchronisers
  sequence pd_held;
    !power_down_n_pin_i [*4];
  endsequence
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("sda_o high");
  a_shutdown_mode: assert property (pd_held |-> ctrl_o.mode == ism_pkg::ISM_MODE_SHUTDOWN)
    else $error("not shutdown");
  a_shutdown_bus: assert property (pd_held |-> !sda_oe_o)
    else $error("bus driven in shutdown");
  a_osc_follows: assert property (ctrl_o.osc_en == act)
    else $error("osc enable off mode");
  a_osc_early: assert property (ctrl_o.osc_ready |-> ctrl_o.osc_en && on_q >= 10'h1f0)
    else $error("osc ready early");
  a_osc_late: assert property (ctrl_o.osc_en && on_q >= 10'h1f8 |-> ctrl_o.osc_ready)
    else $error("osc ready late");
  a_standby_off: assert property (!act |-> ctrl_o.sense_rst && ctrl_o.led_rst && ctrl_o.ch_en == 6'h00)
    else $error("function on outside active");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda moved with scl high");
  a_por_standby: assert property ($rose(power_down_n_pin_i) |-> ##6 ctrl_o.mode == ism_pkg::ISM_MODE_STANDBY)
    else $error("no standby after power-up");
endmodule : ism_core_checker

// >>> dv/ism_i2c_master.sv
// Behavioural I2C master for the target's bus pins.
// Assumes SDA is resolved outside as wired-and with a pull-up.
`timescale 1ns/1ps
module ism_i2c_master (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // 60 clocks a phase: far wider than the few clocks the target's synchronisers need
  localparam time HP = 600;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Doubles as repeated start; SCL stands still between frames
  task automatic start();
    #100;
    sda_low_o = 1'b0;
    #HP;
    scl_o = 1'b1;
    #HP;
    sda_low_o = 1'b1;
    #HP;
    scl_o = 1'b0;
  endtask : start
  task automatic stop();
    #100;
    sda_low_o = 1'b1;
    #HP;
    scl_o = 1'b1;
    #HP;
    sda_low_o = 1'b0;
    #HP;
  endtask : stop
  // Data moves only while SCL is low, away from its falling edge
  task automatic bit_x(input logic b, output logic r);
    #100;
    sda_low_o = !b;
    #HP;
    scl_o = 1'b1;
    #HP;
    r = sda_i;
    scl_o = 1'b0;
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(!mack, r);
    ack = !r;
  endtask : xfer
endmodule : ism_i2c_master

// >>> dv/tb_ism_core.sv
// Self-checking bench: master model traffic against a register model.
// Assumes the checker and master model are compiled first.
`timescale 1ns/1ps
module tb_ism_core;
  localparam int RC = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic addr_sel_i = 1'b0;
  logic pd_n = 1'b0;
  logic sda_oe_o;
  logic scl;
  logic m_low;
  logic sda;
  logic [6:0] own = 7'h2c;
  ism_pkg::ism_ctrl_t ctrl_o;
  int fails = 0;
  int n_tests = 0;
  int mdl[RC];
  assign sda = !(sda_oe_o || m_low);
  ism_core #(.REG_COUNT(RC)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i), .power_down_n_pin_i(pd_n), .ctrl_o(ctrl_o));
  ism_i2c_master i_mst (.sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  initial
  begin
    forever #5 clk_i = !clk_i;
  end
  initial
  begin
    // Planned traffic needs about 83,000 cycles
    #1000000;
    fails++;
    complete_run();
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_ctrl(input logic rdy);
    logic on;
    logic s;
    logic [1:0] m;
    s = mdl[1][1];
    on = pd_n && (s || mdl[1][0]);
    m = on ? 2'h2 : {1'b0, pd_n};
    chk("ctrl", {4'h0, m, on, rdy && on, !(on && s), !(on && mdl[1][0]), (on && s) ? ~6'(mdl[2]) : 6'h00},
      16'(ctrl_o));
  endtask : chk_ctrl
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [15:0] d, input int nb);
    logic [7:0] q;
    logic k;
    logic m;
    m = pd_n && a == (addr_sel_i ? 7'h2d : 7'h2c);
    i_mst.start();
    i_mst.xfer({a, 1'b0}, 1'b0, q, k);
    chk("addr ack", 16'(m), 16'(k));
    if (m)
    begin
      i_mst.xfer(idx, 1'b0, q, k);
      chk("index ack", 16'h0001, 16'(k));
      for (int i = 0; i < nb; i++)
      begin
        i_mst.xfer(d[15 - 8 * i -: 8], 1'b0, q, k);
        chk("data ack", 16'h0001, 16'(k));
      end
    end
    i_mst.stop();
    if (m && nb == 2 && idx == 8'h7f && d == 16'h55aa)
      mdl = '{default: 0};
    else if (m && nb == 2 && idx < RC)
      mdl[idx] = int'(d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input int n, input logic rs);
    logic [7:0] q;
    logic [7:0] h;
    logic k;
    i_mst.start();
    i_mst.xfer({own, 1'b0}, 1'b0, q, k);
    i_mst.xfer(idx, 1'b0, q, k);
    if (!rs)
      i_mst.stop();
    i_mst.start();
    i_mst.xfer({own, 1'b1}, 1'b0, q, k);
    chk("read ack", 16'h0001, 16'(k));
    for (int i = 0; i < n; i++)
    begin
      i_mst.xfer(8'hff, 1'b1, h, k);
      i_mst.xfer(8'hff, i < n - 1, q, k);
      chk("read", (idx + i < RC) ? 16'(mdl[idx + i]) : 16'h0000, {h, q});
    end
    #300;
    chk("release", 16'h0000, 16'(sda_oe_o));
    i_mst.stop();
  endtask : rd
  initial
  begin
    void'($urandom(7478));
    mdl = '{default: 0};
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    wr(own, 8'h03, 16'h1234, 2);
    chk_ctrl(1'b0);
    pd_n = 1'b1;
    repeat (10) @(negedge clk_i);
    chk_ctrl(1'b0);
    for (int s = 0; s < 2; s++)
    begin
      addr_sel_i = s[0];
      own = 7'h2c + 7'(s);
      repeat (5) @(negedge clk_i);
      wr(s[0] ? 7'h2c : 7'h2d, 8'h06, 16'h0bad, 2);
      wr(own, 8'h06, 16'($urandom), 2);
      wr(own, 8'h07, 16'($urandom), 2);
      wr(own, 8'h06, 16'($urandom), 1);
      rd(8'h06, 3 - 2 * s, s[0]);
    end
    pd_n = 1'b0;
    mdl = '{default: 0};
    repeat (10) @(negedge clk_i);
    chk_ctrl(1'b0);
    pd_n = 1'b1;
    repeat (10) @(negedge clk_i);
    rd(8'h07, 1, 1'b1);
    wr(own, 8'h02, 16'($urandom), 2);
    wr(own, 8'h01, 16'h0001, 2);
    chk_ctrl(1'b0);
    repeat (400) @(negedge clk_i);
    chk_ctrl(1'b1);
    wr(own, 8'h01, 16'h0002, 2);
    chk_ctrl(1'b1);
    wr(own, 8'h01, 16'h0003, 2);
    chk_ctrl(1'b1);
    wr(own, 8'h7f, 16'h55aa, 2);
    chk_ctrl(1'b0);
    complete_run();
  end
endmodule : tb_ism_core
bind ism_core ism_core_checker #(.REG_COUNT(REG_COUNT)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i),
  .power_down_n_pin_i(power_down_n_pin_i), .ctrl_o(ctrl_o));
